// ### logic/twm_pkg.sv
/*
  Shared constants of the two-wire master controller: register offsets,
  field positions, reset values, clock figures and the engine state type.
  Assumes a 250 MHz system clock and APB access with 32-bit data.
*/
package twm_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_RATELIN = 8'h04;
  localparam logic [7:0] ADDR_RATEEXP = 8'h08;
  localparam logic [7:0] ADDR_FRAMECTRL = 8'h0c;
  localparam logic [7:0] ADDR_TXDATA = 8'h10;
  localparam logic [7:0] ADDR_RXDATA = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Mode value that turns the two-wire controller on.
  localparam logic [1:0] MODE_TWO_WIRE = 2'h3;

  // Frame control bit positions.
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_SEND_BIT = 2;
  localparam int CMD_RECV_BIT = 3;
  localparam int ACK_LEVEL_BIT = 4;

  // Status bit positions.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;

  // Reset values.
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [4:0] FRAMECTRL_RESET = 5'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Clock figures: a quarter-bit tick runs at four times the reference.
  localparam int CLK_MHZ = 250;
  localparam int REF_MHZ = 12;
  localparam int QUARTERS_PER_BIT = 4;
  localparam logic [8:0] TICK_INC = 9'(REF_MHZ * QUARTERS_PER_BIT);
  localparam logic [8:0] TICK_MOD = 9'(CLK_MHZ);

  // Engine states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_STOP = 4'b0100,
    ST_BYTE = 4'b1000
  } twm_state_t;

endpackage

// ### logic/twm_two_wire_master.sv
/*
  Two-wire master controller with an APB register slave: divider, segment
  engine for start, stop, send and receive, open-drain pin drive.
  Assumes synchronous pin inputs, external pull-ups on SDA and SCL, and a
  single master on the bus.
*/
// Summary of operation
// - The engine runs only while the mode register holds the value 3.
// - The controller is master only and never checks for lost arbitration.
// - Standard 100 kbps and fast 400 kbps rates are both reachable.
// - The bit rate is 12 MHz divided by (linear + 1) times 2 to the exponent.
// - The divider uses the rate registers as last written by software.
// - A slave holding SCL low stalls the engine until SCL reads high.
// - 7-bit and 10-bit addresses are sent as one or two send segments.
// - The pins are only pulled low or released, never driven high.
// - Four command bits request start, stop, send and receive segments.
// - The start command makes a start or, mid-frame, a repeated start.
// - The send command shifts the transmit byte out most significant first.
// - Linear and exponent are four-bit read/write fields resetting to zero.
`timescale 1ns/1ps
module twm_two_wire_master
  import twm_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Open-drain serial data pin.
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // Open-drain serial clock pin.
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file and APB slave.

  logic [1:0] modeSel;
  logic [3:0] rateLin;
  logic [3:0] rateExp;
  logic [4:0] frameCtrl;
  logic [7:0] txData;
  logic [7:0] rxData;
  logic nackSeen;
  logic [1:0] next_modeSel;
  logic [3:0] next_rateLin;
  logic [3:0] next_rateExp;
  logic [4:0] next_frameCtrl;
  logic [7:0] next_txData;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic busWrite;
  logic mapped;
  logic [4:0] cmdDone;
  logic busy;

  twm_state_t state;
  twm_state_t next_state;

  // The answer is registered in the setup cycle, so every access takes
  // exactly one access-phase cycle with no wait states.
  always_comb
  begin
    busWrite = psel && penable && pready && pwrite;
    mapped = (paddr == ADDR_MODE) || (paddr == ADDR_RATELIN) ||
             (paddr == ADDR_RATEEXP) || (paddr == ADDR_FRAMECTRL) ||
             (paddr == ADDR_TXDATA) || (paddr == ADDR_RXDATA) ||
             (paddr == ADDR_STATUS);
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    next_prdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      case (paddr)
        ADDR_MODE: next_prdata = {30'h0, modeSel};
        ADDR_RATELIN: next_prdata = {28'h0, rateLin};
        ADDR_RATEEXP: next_prdata = {28'h0, rateExp};
        ADDR_FRAMECTRL: next_prdata = {27'h0, frameCtrl};
        ADDR_TXDATA: next_prdata = {24'h0, txData};
        ADDR_RXDATA: next_prdata = {24'h0, rxData};
        ADDR_STATUS: next_prdata = {30'h0, nackSeen, busy};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    next_modeSel = modeSel;
    next_rateLin = rateLin;
    next_rateExp = rateExp;
    next_txData = txData;
    // A finished segment drops its command bit; a software write in the
    // same cycle wins so a freshly issued command is never lost.
    next_frameCtrl = frameCtrl & ~cmdDone;
    if (busWrite)
    begin
      case (paddr)
        ADDR_MODE: next_modeSel = pwdata[1:0];
        ADDR_RATELIN: next_rateLin = pwdata[3:0];
        ADDR_RATEEXP: next_rateExp = pwdata[3:0];
        ADDR_FRAMECTRL: next_frameCtrl = pwdata[4:0];
        ADDR_TXDATA: next_txData = pwdata[7:0];
        default: next_txData = txData;
      endcase
    end
  end

  // Register stage of the bus slave.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      modeSel <= MODE_RESET;
      rateLin <= RATE_RESET;
      rateExp <= RATE_RESET;
      frameCtrl <= FRAMECTRL_RESET;
      txData <= DATA_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clkEn)
    begin
      modeSel <= next_modeSel;
      rateLin <= next_rateLin;
      rateExp <= next_rateExp;
      frameCtrl <= next_frameCtrl;
      txData <= next_txData;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit timing and segment engine.

  logic [8:0] tickAcc;
  logic [19:0] qCnt;
  logic [1:0] qIdx;
  logic [3:0] bitIdx;
  logic [7:0] shiftReg;
  logic isRecv;
  logic sdaPull;
  logic sclPull;
  logic [8:0] next_tickAcc;
  logic [19:0] next_qCnt;
  logic [1:0] next_qIdx;
  logic [3:0] next_bitIdx;
  logic [7:0] next_shiftReg;
  logic next_isRecv;
  logic next_sdaPull;
  logic next_sclPull;
  logic [7:0] next_rxData;
  logic next_nackSeen;
  logic [8:0] tickSum;
  logic tick;
  logic stall;
  logic [19:0] qLimit;
  logic qDone;
  logic enabled;

  // Pull level for the data line during bit b of a byte segment.
  function automatic logic sdaForBit(input logic recv, input logic [3:0] b,
                                     input logic msb, input logic ackLvl);
    if (b == 4'h8)
      sdaForBit = recv ? !ackLvl : 1'b0;
    else
      sdaForBit = recv ? 1'b0 : !msb;
  endfunction

  // The 48 MHz quarter-bit tick is made by a fractional accumulator, which trades
  // a little edge jitter for an exact long-term rate from 250 MHz.
  always_comb
  begin
    enabled = (modeSel == MODE_TWO_WIRE);
    tickSum = tickAcc + TICK_INC;
    tick = (tickSum >= TICK_MOD);
    next_tickAcc = tick ? tickSum - TICK_MOD : tickSum;
    qLimit = 20'(({16'h0000, rateLin} + 20'h00001) << rateExp);
    stall = !sclPull && !sclIn;
    qDone = tick && !stall && (qCnt == qLimit - 20'h00001);
    next_state = state;
    next_qCnt = qCnt;
    next_qIdx = qIdx;
    next_bitIdx = bitIdx;
    next_shiftReg = shiftReg;
    next_isRecv = isRecv;
    next_sdaPull = sdaPull;
    next_sclPull = sclPull;
    next_rxData = rxData;
    next_nackSeen = nackSeen;
    cmdDone = 5'h00;
    if (tick)
      next_qCnt = (qDone || stall) ? 20'h00000 : qCnt + 20'h00001;
    case (state)
      ST_IDLE:
      begin
        next_qCnt = 20'h00000;
        next_qIdx = 2'h0;
        next_bitIdx = 4'h0;
        if (!enabled)
        begin
          next_sdaPull = 1'b0;
          next_sclPull = 1'b0;
        end
        else if (frameCtrl[CMD_START_BIT])
        begin
          next_state = ST_START;
          next_sdaPull = 1'b0;
        end
        else if (frameCtrl[CMD_SEND_BIT] || frameCtrl[CMD_RECV_BIT])
        begin
          next_state = ST_BYTE;
          next_isRecv = !frameCtrl[CMD_SEND_BIT];
          next_shiftReg = txData;
          next_sdaPull = sdaForBit(!frameCtrl[CMD_SEND_BIT], 4'h0,
                                   txData[7], frameCtrl[ACK_LEVEL_BIT]);
        end
        else if (frameCtrl[CMD_STOP_BIT])
        begin
          next_state = ST_STOP;
          next_sdaPull = 1'b1;
        end
      end
      ST_START:
      begin
        // Release SCL, pull SDA low while SCL is high, then pull SCL low.
        if (qDone)
        begin
          next_qIdx = qIdx + 2'h1;
          case (qIdx)
            2'h0: next_sclPull = 1'b0;
            2'h1: next_sdaPull = 1'b1;
            2'h2: next_sclPull = 1'b1;
            default:
            begin
              next_state = ST_IDLE;
              cmdDone[CMD_START_BIT] = 1'b1;
            end
          endcase
        end
      end
      ST_STOP:
      begin
        // SDA rises while SCL is high; both lines end released.
        if (qDone)
        begin
          next_qIdx = qIdx + 2'h1;
          case (qIdx)
            2'h0: next_sclPull = 1'b0;
            2'h1: next_sdaPull = 1'b0;
            2'h2: next_sdaPull = 1'b0;
            default:
            begin
              next_state = ST_IDLE;
              cmdDone[CMD_STOP_BIT] = 1'b1;
            end
          endcase
        end
      end
      ST_BYTE:
      begin
        // Nine bits of four quarters: two low, one released, one high.
        if (qDone)
        begin
          next_qIdx = qIdx + 2'h1;
          case (qIdx)
            2'h0: next_sclPull = 1'b1;
            2'h1: next_sclPull = 1'b0;
            2'h2:
            begin
              if (bitIdx == 4'h8 && !isRecv)
                next_nackSeen = sdaIn;
              else if (isRecv && bitIdx != 4'h8)
                next_shiftReg = {shiftReg[6:0], sdaIn};
              else if (!isRecv)
                next_shiftReg = {shiftReg[6:0], 1'b0};
            end
            default:
            begin
              next_sclPull = 1'b1;
              next_bitIdx = bitIdx + 4'h1;
              next_sdaPull = sdaForBit(isRecv, bitIdx + 4'h1,
                                       shiftReg[7],
                                       frameCtrl[ACK_LEVEL_BIT]);
              if (bitIdx == 4'h8)
              begin
                next_state = ST_IDLE;
                next_sdaPull = 1'b0;
                if (isRecv)
                  next_rxData = shiftReg;
                cmdDone[CMD_SEND_BIT] = !isRecv;
                cmdDone[CMD_RECV_BIT] = isRecv;
              end
            end
          endcase
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Losing the mode mid-segment abandons it and frees both lines.
    if (!enabled && state != ST_IDLE)
    begin
      next_state = ST_IDLE;
      next_sdaPull = 1'b0;
      next_sclPull = 1'b0;
    end
    busy = (state != ST_IDLE);
  end

  // Register stage of the engine; the pins never drive high and no
  // arbitration check exists, so only one master may share the bus.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      tickAcc <= 9'h000;
      qCnt <= 20'h00000;
      qIdx <= 2'h0;
      bitIdx <= 4'h0;
      shiftReg <= DATA_RESET;
      isRecv <= 1'b0;
      sdaPull <= 1'b0;
      sclPull <= 1'b0;
      rxData <= DATA_RESET;
      nackSeen <= 1'b0;
      sdaOut <= 1'b0;
      sdaOeN <= 1'b1;
      sclOut <= 1'b0;
      sclOeN <= 1'b1;
    end
    else if (clkEn)
    begin
      state <= next_state;
      tickAcc <= next_tickAcc;
      qCnt <= next_qCnt;
      qIdx <= next_qIdx;
      bitIdx <= next_bitIdx;
      shiftReg <= next_shiftReg;
      isRecv <= next_isRecv;
      sdaPull <= next_sdaPull;
      sclPull <= next_sclPull;
      rxData <= next_rxData;
      nackSeen <= next_nackSeen;
      sdaOut <= 1'b0;
      sdaOeN <= !next_sdaPull;
      sclOut <= 1'b0;
      sclOeN <= !next_sclPull;
    end
  end

endmodule // twm_two_wire_master

// ### sim/twm_two_wire_master_assertions.sv
/*
  Port checker of the two-wire master: APB answer timing, pin drive,
  release at reset and the stall while a slave stretches SCL.
  Assumes clkEn is held high by the surroundings.
*/
`timescale 1ns/1ps
module twm_two_wire_master_assertions
  import twm_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire logic sdaOut,
  input wire logic sdaOeN,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOeN
);
  // Frozen cycles would stretch every figure, so they are exempt.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !clkEn);
  ////////////////////////////////////////
  // Pins are only ever pulled low or let go.
  a_sda_only_pull: assert property (sdaOut == 1'h0)
    else $error("sda output not low");
  a_scl_only_pull: assert property (sclOut == 1'h0)
    else $error("scl output not low");
  a_reset_release: assert property (disable iff (!clkEn)
    reset |=> sdaOeN && sclOeN && !pready)
    else $error("lines held after reset");
  // Register access answers one cycle after setup.
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (psel && !penable &&
    paddr[1:0] == 2'h0 |=> pslverr == ($past(paddr) > ADDR_STATUS))
    else $error("wrong error answer");
  a_idle_data_zero: assert property (!pready |->
    prdata == 32'h0 && !pslverr)
    else $error("data while not answering");
  // A held SCL freezes the engine.
  a_stretch_stall: assert property (sclOeN && !sclIn |=>
    $stable(sdaOeN) && sclOeN)
    else $error("engine moved during stretch");
endmodule // twm_two_wire_master_assertions

bind twm_two_wire_master twm_two_wire_master_assertions u_chk(
  .clk(clk), .reset(reset), .clkEn(clkEn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclIn(sclIn),
  .sclOut(sclOut), .sclOeN(sclOeN));

// ### sim/twm_slave_model.sv
/*
  Slave on the two-wire bus: acks, serves read bytes, stretches SCL.
  Assumes the bench forms wired-AND levels with pull-ups.
*/
`timescale 1ns/1ps
module twm_slave_model
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Wire levels and pull-downs, 0 pulls low.
  input wire logic sda,
  input wire logic scl,
  output logic slvSda,
  output logic slvScl,
  // Controls and observations.
  input wire logic ackOff,
  input wire logic [7:0] txByte,
  input wire logic [7:0] stretch,
  output logic [7:0] rxByte,
  output logic mAck,
  output int nStart,
  output int nStop,
  output int period
);
  logic pSda, pScl, rd, first, rdN;
  logic [7:0] sh;
  int bits, hold, cyc;
  // A count keeps the stall a known length.
  assign slvScl = (hold == 0);
  ////////////////////////////////////////
  // Framing, shifting and answers on sampled wire edges.
  always @(posedge clk)
  begin
    pSda <= sda;
    pScl <= scl;
    cyc <= cyc + 1;
    if (hold > 0)
      hold <= hold - 1;
    if (reset)
    begin
      slvSda <= 1'h1;
      bits <= 0;
      nStart <= 0;
      nStop <= 0;
      hold <= 0;
      mAck <= 1'h1;
    end
    else if (pScl && scl && pSda && !sda)
    begin
      nStart <= nStart + 1;
      bits <= 0;
      first <= 1'h1;
      rd <= 1'h0;
    end
    else if (pScl && scl && !pSda && sda)
    begin
      nStop <= nStop + 1;
      rd <= 1'h0;
    end
    else if (!pScl && scl)
    begin
      period <= cyc;
      cyc <= 0;
      sh <= {sh[6:0], sda};
      if (bits == 7)
        rxByte <= {sh[6:0], sda};
      if (bits == 8)
        mAck <= sda;
      bits <= bits + 1;
    end
    else if (pScl && !scl)
    begin
      hold <= stretch;
      rdN = first ? rxByte[0] : rd && !mAck;
      if (bits == 8)
        slvSda <= rd | ackOff;
      else if (bits == 9)
      begin
        bits <= 0;
        first <= 1'h0;
        rd <= rdN;
        slvSda <= !rdN | txByte[7];
      end
      else if (bits > 0)
        slvSda <= !rd | txByte[7 - bits];
    end
  end
endmodule // twm_slave_model

// ### sim/tb_top.sv
/*
  Bench of the two-wire master: registers, mode gate, frames, rates.
  Assumes the slave model and pull-ups on both wires.
*/
`timescale 1ns/1ps
module tb_top;
  import twm_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = 8'h00, rxByte;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, sdaOut, sdaOeN, sclOut, sclOeN;
  logic slvSda, slvScl, ackOff = 0, mAck;
  logic [7:0] txByte = 8'hc3, stretch = 8'h00;
  int n_mismatch = 0, n_checks = 0, nStart, nStop, period, cyc = 0;
  wire sda = sdaOeN & slvSda;
  wire scl = sclOeN & slvScl;
  always #2 clk = ~clk;
  twm_two_wire_master u_dut(.clk(clk), .reset(reset), .clkEn(1'h1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .sclIn(scl), .sclOut(sclOut), .sclOeN(sclOeN));
  twm_slave_model u_slv(.clk(clk), .reset(reset), .sda(sda), .scl(scl),
    .slvSda(slvSda), .slvScl(slvScl), .ackOff(ackOff), .txByte(txByte),
    .stretch(stretch), .rxByte(rxByte), .mAck(mAck), .nStart(nStart),
    .nStop(nStop), .period(period));
  ////////////////////////////////////////
  // One APB transfer, entered just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkIn(input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, v, lo);
    end
  endtask
  // Polling stands in for an interrupt the block does not have.
  task automatic wt();
    repeat (9000)
    begin
      apb(1'h0, ADDR_FRAMECTRL, 32'h0);
      if (r[3:0] === 4'h0)
        break;
    end
    chk(32'(r[3:0]), 32'h0);
  endtask
  task automatic seg(input logic [4:0] c);
    apb(1'h1, ADDR_FRAMECTRL, 32'(c));
    wt();
  endtask
  task automatic snd(input logic [7:0] b, input logic nk);
    apb(1'h1, ADDR_TXDATA, 32'(b));
    seg(5'h04);
    chk(32'(rxByte), 32'(b));
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'(r[STAT_NACK_BIT]), 32'(nk));
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] a [2] = '{ADDR_RATELIN, ADDR_RATEEXP};
    foreach (a[i])
    begin
      apb(1'h0, a[i], 32'h0);
      chk(r, 32'h0);
      apb(1'h1, a[i], 32'hffffffff);
      apb(1'h0, a[i], 32'h0);
      chk(r, 32'hf);
    end
    apb(1'h0, 8'h1c, 32'h0);
    chk({r[30:0], e}, 32'h1);
  endtask
  task automatic t_mode();
    apb(1'h1, ADDR_RATELIN, 32'h0);
    apb(1'h1, ADDR_RATEEXP, 32'h0);
    apb(1'h1, ADDR_FRAMECTRL, 32'h1);
    repeat (100) @(posedge clk);
    apb(1'h0, ADDR_FRAMECTRL, 32'h0);
    chk({r[29:0], sda, scl}, 32'h7);
    chk(32'(nStart), 32'h0);
    apb(1'h1, ADDR_MODE, 32'(MODE_TWO_WIRE));
    wt();
    chk(32'(nStart), 32'h1);
  endtask
  task automatic t_write();
    snd(8'hf2, 1'h0);
    snd(8'h34, 1'h0);
    seg(5'h01);
    ackOff <= 1'h1;
    snd(8'h5b, 1'h1);
    ackOff <= 1'h0;
    seg(5'h01);
    chk(32'(nStart), 32'h3);
    seg(5'h02);
    chk(32'(nStop), 32'h1);
  endtask
  task automatic t_read();
    seg(5'h01);
    snd(8'ha5, 1'h0);
    seg(5'h08);
    apb(1'h0, ADDR_RXDATA, 32'h0);
    chk({r[30:0], mAck}, 32'h186);
    seg(5'h18);
    chk(32'(mAck), 32'h1);
    seg(5'h02);
  endtask
  task automatic t_stretch();
    stretch <= 8'h64;
    seg(5'h01);
    snd(8'h96, 1'h0);
    chkIn(period, 100, 130);
    stretch <= 8'h00;
    seg(5'h02);
  endtask
  // Standard, reduced fast and fast settings; periods in 4 ns cycles.
  task automatic t_rate();
    int lin [3] = '{14, 15, 14};
    int ex [3] = '{3, 1, 1};
    int p;
    seg(5'h01);
    foreach (lin[i])
    begin
      p = 250 * (lin[i] + 1) * (1 << ex[i]) / 12;
      apb(1'h1, ADDR_RATELIN, 32'(lin[i]));
      apb(1'h1, ADDR_RATEEXP, 32'(ex[i]));
      snd(8'h3c, 1'h0);
      chkIn(period, p - 1, p + 2);
    end
    seg(5'h02);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // The ceiling sits well above the slow-rate frame length.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    t_regs();
    t_mode();
    t_write();
    t_read();
    t_stretch();
    t_rate();
    results();
  end
endmodule // tb_top
